//--- design/image_statistics_readout.v
// per-frame image statistics registers and pixel dump test port
//
// Functional notes
// - feature count register is upper eight bits of nine-bit feature count
// - feature count register never exceeds 162
// - sixteen-bit exposure in clock cycles, high and low byte registers
// - exposure self-adjusts to keep average and peak pixel in range
// - brightest pixel of frame, 0 to 254, updated every frame
// - darkest pixel of frame, 0 to 254, updated every frame
// - any write to dump register resets pointer to pixel 0,0
// - during a dump one pixel per frame is captured
// - dump-word-valid flag set when dump data valid; controller waits for it
// - reading dump register while dump-word-valid is set advances pointer to next pixel
// - after full frame, pointer wraps and frame-start flag marks first pixel
`include "image_stats_defs.vh"

module image_statistics_readout #(
    parameter FRAME_PIXELS = `FRAME_PIXELS,
    parameter IDX_W        = 9,
    parameter FIFO_DEPTH   = 4,
    parameter FIFO_ADDR_W  = 2
) (
    // clock and reset
    input  wire       sys_clk,
    input  wire       arst_n,
    // pixel stream from the image array
    input  wire [7:0] pixData,
    input  wire       dump_frame_start,
    input  wire       pixValid,
    output wire       pixReady,
    // register port from the serial interface
    input  wire [7:0] regAddr,
    input  wire       regRd,
    input  wire       regWr,
    input  wire [7:0] regWrData,
    output wire [7:0] regRdData,
    // flags toward the motion status register
    output wire       dumpWordValid,
    output wire       dumpFrameStart
);
    localparam [IDX_W-1:0] LAST_IDX = FRAME_PIXELS - 1;
    // exposure reset value; its low byte is seen by the 0x07 read before any 0x06 read
    localparam [15:0]      RST_EXPO = `RST_EXPOSURE_TIME;

    // fifo drain side
    wire [8:0] fifoData;
    wire       fifoValid;
    wire       drainReady;
    wire       take;

    // register strobes
    wire       dumpWrite;
    wire       dumpRead;
    wire       expoHighRead;

    // published statistics
    reg [7:0]  featureReg_r;
    reg [15:0] expo_r;
    reg [7:0]  expoLowHold_r;
    reg [7:0]  brightReg_r;
    reg [7:0]  totalReg_r;
    reg [7:0]  darkReg_r;
    reg [7:0]  regRdData_r;

    // per-frame accumulators
    reg [IDX_W-1:0] pixIdx_r;
    reg [7:0]       curMax_r;
    reg [7:0]       curMin_r;
    reg [16:0]      curSum_r;
    reg [8:0]       curFeat_r;
    reg [7:0]       prevPix_r;

    // dump port state
    reg [IDX_W-1:0] dumpPtr_r;
    reg [7:0]       dumpData_r;
    reg             dumpValid_r;
    reg             dumpFirst_r;

    // combinational frame values including the pixel being taken
    reg [IDX_W-1:0] idx;
    reg [7:0]       pv;
    reg [7:0]       diff;
    reg             isFeat;
    reg [7:0]       fMax;
    reg [7:0]       fMin;
    reg [16:0]      fSum;
    reg [8:0]       fFeat;
    reg             lastPix;
    reg [16:0]      expoStep;
    reg [16:0]      expo_nxt;
    reg [7:0]       rdMux;

    pixel_fifo #(
        .WIDTH  (9),
        .DEPTH  (FIFO_DEPTH),
        .ADDR_W (FIFO_ADDR_W)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .inData   ({dump_frame_start, pixData}),
        .inValid  (pixValid),
        .inReady  (pixReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (drainReady)
    );

    assign dumpWrite    = regWr && (regAddr == `OFS_FRAME_DUMP_DATA);
    assign dumpRead     = regRd && (regAddr == `OFS_FRAME_DUMP_DATA);
    assign expoHighRead = regRd && (regAddr == `OFS_EXPOSURE_TIME_HIGH);
    // hold the stream one cycle while the dump pointer restarts so no pixel races it
    assign drainReady   = !dumpWrite;
    assign take         = fifoValid && drainReady;

    assign regRdData      = regRdData_r;
    assign dumpWordValid  = dumpValid_r;
    assign dumpFrameStart = dumpFirst_r;

    always @* begin
        idx     = fifoData[8] ? {IDX_W{1'b0}} : pixIdx_r;
        pv      = (fifoData[7:0] > `PIXEL_CLAMP) ? `PIXEL_CLAMP : fifoData[7:0];
        diff    = (pv > prevPix_r) ? (pv - prevPix_r) : (prevPix_r - pv);
        isFeat  = (idx != {IDX_W{1'b0}}) && (diff > `FEATURE_DIFF_THRESH);
        lastPix = (idx == LAST_IDX);
        if (idx == {IDX_W{1'b0}}) begin
            fMax  = pv;
            fMin  = pv;
            fSum  = {9'h000, pv};
            fFeat = 9'h000;
        end else begin
            fMax  = (pv > curMax_r) ? pv : curMax_r;
            fMin  = (pv < curMin_r) ? pv : curMin_r;
            fSum  = curSum_r + {9'h000, pv};
            fFeat = curFeat_r;
        end
        // saturate so the reported upper bits stop at 162
        if (isFeat && (fFeat < `FEATURE_COUNT_MAX)) begin
            fFeat = fFeat + 9'h001;
        end
    end

    // exposure regulation, one step per frame
    always @* begin
        expoStep = {1'b0, expo_r} >> `EXPO_STEP_SHIFT;
        expo_nxt = {1'b0, expo_r};
        if ((fMax > `EXPO_PEAK_HIGH) ||
            (fSum[`PIXEL_TOTAL_MSB:`PIXEL_TOTAL_LSB] > `EXPO_AVG_HIGH)) begin
            expo_nxt = {1'b0, expo_r} - expoStep;
            if (expo_nxt < {1'b0, `EXPO_MIN}) begin
                expo_nxt = {1'b0, `EXPO_MIN};
            end
        end else if (fSum[`PIXEL_TOTAL_MSB:`PIXEL_TOTAL_LSB] < `EXPO_AVG_LOW) begin
            expo_nxt = {1'b0, expo_r} + expoStep + 17'h00001;
            if (expo_nxt > {1'b0, `EXPO_MAX}) begin
                expo_nxt = {1'b0, `EXPO_MAX};
            end
        end
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pixIdx_r     <= {IDX_W{1'b0}};
            curMax_r     <= 8'h00;
            curMin_r     <= 8'h00;
            curSum_r     <= 17'h00000;
            curFeat_r    <= 9'h000;
            prevPix_r    <= 8'h00;
            featureReg_r <= `RST_SURFACE_FEATURE_COUNT;
            expo_r       <= `RST_EXPOSURE_TIME;
            brightReg_r  <= `RST_BRIGHTEST_PIXEL;
            totalReg_r   <= `RST_PIXEL_TOTAL_HIGH;
            darkReg_r    <= `RST_DARKEST_PIXEL;
        end else if (take) begin
            pixIdx_r  <= lastPix ? {IDX_W{1'b0}} : idx + 1'b1;
            curMax_r  <= fMax;
            curMin_r  <= fMin;
            curSum_r  <= fSum;
            curFeat_r <= fFeat;
            prevPix_r <= pv;
            if (lastPix) begin
                featureReg_r <= fFeat[`FEATURE_REPORT_MSB:`FEATURE_REPORT_LSB];
                brightReg_r  <= fMax;
                darkReg_r    <= fMin;
                totalReg_r   <= fSum[`PIXEL_TOTAL_MSB:`PIXEL_TOTAL_LSB];
                expo_r       <= expo_nxt[15:0];
            end
        end
    end

    // dump pointer and capture
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dumpPtr_r   <= {IDX_W{1'b0}};
            dumpData_r  <= `RST_FRAME_DUMP_DATA;
            dumpValid_r <= 1'b0;
            dumpFirst_r <= 1'b0;
        end else if (dumpWrite) begin
            dumpPtr_r   <= {IDX_W{1'b0}};
            dumpValid_r <= 1'b0;
            dumpFirst_r <= 1'b0;
        end else if (dumpRead && dumpValid_r) begin
            dumpPtr_r   <= (dumpPtr_r == LAST_IDX) ? {IDX_W{1'b0}} : dumpPtr_r + 1'b1;
            dumpValid_r <= 1'b0;
        end else if (take && !dumpValid_r && (idx == dumpPtr_r)) begin
            // the matching index occurs once per frame, so one capture per frame
            dumpData_r  <= pv;
            dumpValid_r <= 1'b1;
            dumpFirst_r <= (dumpPtr_r == {IDX_W{1'b0}});
        end
    end

    // low exposure byte is frozen when the high byte is read to keep the pair coherent
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            expoLowHold_r <= RST_EXPO[7:0];
        end else if (expoHighRead) begin
            expoLowHold_r <= expo_r[7:0];
        end
    end

    always @* begin
        case (regAddr)
            `OFS_SURFACE_FEATURE_COUNT: begin
                rdMux = featureReg_r;
            end
            `OFS_EXPOSURE_TIME_HIGH: begin
                rdMux = expo_r[15:8];
            end
            `OFS_EXPOSURE_TIME_LOW: begin
                rdMux = expoLowHold_r;
            end
            `OFS_BRIGHTEST_PIXEL: begin
                rdMux = brightReg_r;
            end
            `OFS_PIXEL_TOTAL_HIGH: begin
                rdMux = totalReg_r;
            end
            `OFS_DARKEST_PIXEL: begin
                rdMux = darkReg_r;
            end
            `OFS_FRAME_DUMP_DATA: begin
                rdMux = dumpData_r;
            end
            default: begin
                rdMux = 8'h00;
            end
        endcase
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData_r <= 8'h00;
        end else if (regRd) begin
            regRdData_r <= rdMux;
        end
    end
endmodule

//--- common/image_stats_defs.vh
// offsets, field limits, reset values and tuning constants of the image statistics block
`ifndef IMAGE_STATS_DEFS_VH
`define IMAGE_STATS_DEFS_VH

// register offsets
`define OFS_SURFACE_FEATURE_COUNT 8'h05
`define OFS_EXPOSURE_TIME_HIGH    8'h06
`define OFS_EXPOSURE_TIME_LOW     8'h07
`define OFS_BRIGHTEST_PIXEL       8'h08
`define OFS_PIXEL_TOTAL_HIGH      8'h09
`define OFS_DARKEST_PIXEL         8'h0A
`define OFS_FRAME_DUMP_DATA       8'h0B

// reset values
`define RST_SURFACE_FEATURE_COUNT 8'h00
`define RST_EXPOSURE_TIME         16'h0064
`define RST_BRIGHTEST_PIXEL       8'hD0
`define RST_PIXEL_TOTAL_HIGH      8'h80
`define RST_DARKEST_PIXEL         8'h00
`define RST_FRAME_DUMP_DATA       8'h00

// field layout and limits
`define PIXEL_CLAMP               8'hFE
`define FEATURE_COUNT_MAX         9'h145
`define FEATURE_REPORT_MSB        8
`define FEATURE_REPORT_LSB        1
`define PIXEL_TOTAL_MSB           16
`define PIXEL_TOTAL_LSB           9
`define FRAME_PIXELS              484

// feature threshold and exposure regulation targets
`define FEATURE_DIFF_THRESH       8'h10
`define EXPO_PEAK_HIGH            8'hF0
`define EXPO_AVG_HIGH             8'hA0
`define EXPO_AVG_LOW              8'h60
`define EXPO_STEP_SHIFT           4
`define EXPO_MIN                  16'h0010
`define EXPO_MAX                  16'hFFF0

`endif

//--- design/pixel_fifo.v
// small synchronous fifo carrying pixel words into the statistics engine
module pixel_fifo #(
    parameter WIDTH  = 9,
    parameter DEPTH  = 4,
    parameter ADDR_W = 2
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             arst_n,
    // fill side
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    // drain side
    output wire [WIDTH-1:0] outData,
    output wire             outValid,
    input  wire             outReady
);
    reg [WIDTH-1:0]  mem [0:DEPTH-1];
    reg [ADDR_W-1:0] wrPtr_r;
    reg [ADDR_W-1:0] rdPtr_r;
    reg [ADDR_W:0]   count_r;
    reg [ADDR_W:0]   count_nxt;
    reg              notFull_r;
    wire             push;
    wire             pop;

    assign inReady  = notFull_r;
    assign outValid = (count_r != {(ADDR_W+1){1'b0}});
    assign outData  = mem[rdPtr_r];
    assign push     = inValid && notFull_r;
    assign pop      = outValid && outReady;

    always @* begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    // full is registered so the fill side sees a clean ready
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_r   <= {ADDR_W{1'b0}};
            rdPtr_r   <= {ADDR_W{1'b0}};
            count_r   <= {(ADDR_W+1){1'b0}};
            notFull_r <= 1'b1;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == DEPTH - 1) ? {ADDR_W{1'b0}} : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == DEPTH - 1) ? {ADDR_W{1'b0}} : rdPtr_r + 1'b1;
            end
            count_r   <= count_nxt;
            notFull_r <= (count_nxt != DEPTH);
        end
    end
endmodule

//--- testbench/image_statistics_readout_properties.sv
// port-level checks for the image statistics readout block
module image_statistics_readout_properties (
    // clock and reset
    input wire       sys_clk,
    input wire       arst_n,
    // pixel stream
    input wire [7:0] pixData,
    input wire       dump_frame_start,
    input wire       pixValid,
    input wire       pixReady,
    // register port
    input wire [7:0] regAddr,
    input wire       regRd,
    input wire       regWr,
    input wire [7:0] regWrData,
    input wire [7:0] regRdData,
    // flags
    input wire       dumpWordValid,
    input wire       dumpFrameStart
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    wire rdDump = regRd && regAddr == 8'h0B;
    wire wrDump = regWr && regAddr == 8'h0B;

    AST_FEATURE_MAX: assert property (regRd && regAddr == 8'h05 |=> regRdData <= 8'd162)
        else $error("feature count over limit");
    AST_BRIGHT_MAX: assert property (regRd && regAddr == 8'h08 |=> regRdData <= 8'hFE)
        else $error("brightest pixel over limit");
    AST_DARK_MAX: assert property (regRd && regAddr == 8'h0A |=> regRdData <= 8'hFE)
        else $error("darkest pixel over limit");
    AST_DUMP_MAX: assert property (rdDump |=> regRdData <= 8'hFE)
        else $error("dump word over limit");
    AST_WRITE_CLEARS: assert property (wrDump |=> !dumpWordValid)
        else $error("dump write left word valid");
    AST_READ_CLEARS: assert property (rdDump && dumpWordValid |=> !dumpWordValid)
        else $error("dump read left word valid");
    AST_VALID_HOLDS: assert property (dumpWordValid && !rdDump && !wrDump |=> dumpWordValid)
        else $error("dump word valid dropped unread");
    AST_START_WITH_WORD: assert property ($rose(dumpFrameStart) |-> $rose(dumpWordValid))
        else $error("frame start without new word");
    AST_DATA_HOLDS: assert property (!regRd |=> $stable(regRdData))
        else $error("read data changed without read");
endmodule

bind image_statistics_readout image_statistics_readout_properties u_props (
    .sys_clk(sys_clk), .arst_n(arst_n), .pixData(pixData), .dump_frame_start(dump_frame_start),
    .pixValid(pixValid), .pixReady(pixReady), .regAddr(regAddr), .regRd(regRd),
    .regWr(regWr), .regWrData(regWrData), .regRdData(regRdData),
    .dumpWordValid(dumpWordValid), .dumpFrameStart(dumpFrameStart)
);

//--- testbench/pixel_array_model.sv
// pixel array source: one frame of alternating low and high pixels per go pulse
module pixel_array_model #(
    parameter int FRAME = 8
) (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       go,
    input  wire logic [7:0] loV,
    input  wire logic [7:0] hiV,
    output logic      [7:0] pixData,
    output logic            dump_frame_start,
    output logic            pixValid,
    input  wire logic       pixReady
);
    timeunit 1ns;
    timeprecision 1ns;
    int idx;
    // idle data is inverted so a stale word never looks valid
    assign pixData = !pixValid ? ~loV : (idx[0] ? hiV : loV);
    assign dump_frame_start = (idx == 0);
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pixValid <= 1'b0;
            idx <= 0;
        end else if (!pixValid) begin
            pixValid <= go;
        end else if (pixReady) begin
            idx <= (idx == FRAME - 1) ? 0 : idx + 1;
            pixValid <= (idx != FRAME - 1);
        end
    end
endmodule

//--- testbench/image_statistics_readout_tb_top.sv
// self-checking bench for the image statistics readout block
module image_statistics_readout_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FRAME = 8;
    logic       sys_clk;
    logic       arst_n;
    wire  [7:0] pixData;
    wire        dump_frame_start;
    wire        pixValid;
    wire        pixReady;
    logic [7:0] regAddr;
    logic       regRd;
    logic       regWr;
    logic [7:0] regWrData;
    wire  [7:0] regRdData;
    wire        dumpWordValid;
    wire        dumpFrameStart;
    logic       go;
    logic [7:0] loV;
    logic [7:0] hiV;
    logic [7:0] e;
    int         mismatches;
    int         comparisons;
    int         k;
    int         f;
    logic [7:0] rstTab [12] = '{8'h00, 8'h00, 8'h00, 8'h64, 8'hD0, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] sa [6] = '{8'h05, 8'h08, 8'h0A, 8'h09, 8'h06, 8'h07};
    logic [7:0] se [2][6] = '{'{8'h03, 8'hFE, 8'h20, 8'h02, 8'h00, 8'h5E},
                              '{8'h00, 8'h18, 8'h10, 8'h00, 8'h00, 8'h64}};

    image_statistics_readout #(.FRAME_PIXELS(FRAME)) u_dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .pixData(pixData), .dump_frame_start(dump_frame_start),
        .pixValid(pixValid), .pixReady(pixReady), .regAddr(regAddr), .regRd(regRd),
        .regWr(regWr), .regWrData(regWrData), .regRdData(regRdData),
        .dumpWordValid(dumpWordValid), .dumpFrameStart(dumpFrameStart)
    );

    pixel_array_model #(.FRAME(FRAME)) u_src (
        .sys_clk(sys_clk), .arst_n(arst_n), .go(go), .loV(loV), .hiV(hiV), .pixData(pixData),
        .dump_frame_start(dump_frame_start), .pixValid(pixValid), .pixReady(pixReady)
    );

    task automatic chk(input string n, input logic [7:0] ex, input logic [7:0] got);
        comparisons++;
        if (got !== ex) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, ex, got);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 chk($sformatf("reg%h", a), ex, regRdData);
    endtask

    task automatic wr(input logic [7:0] a);
        regAddr <= a;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
        #1;
    endtask

    // one frame, then room for the statistics to publish
    task automatic frame(input logic [7:0] lo, input logic [7:0] hi);
        int n;
        n = 0;
        loV <= lo;
        hiV <= hi;
        go <= 1'b1;
        @(posedge sys_clk);
        #1 go <= 1'b0;
        while (pixValid && n < 50) begin
            @(posedge sys_clk);
            #1 n++;
        end
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic conclude;
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        conclude();
    end

    initial begin
        arst_n = 1'b0;
        regAddr = 8'h00;
        regRd = 1'b0;
        regWr = 1'b0;
        regWrData = 8'h5A;
        go = 1'b0;
        loV = 8'h00;
        hiV = 8'h00;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        #1 chk("valid", 8'h00, {7'h00, dumpWordValid});
        chk("ready", 8'h01, {7'h00, pixReady});
        for (k = 0; k < 12; k++) rd(8'h04 + 8'(k), rstTab[k]);
        // motion and displacement offsets read in sequence live outside this block
        for (k = 2; k < 5; k++) rd(8'(k), 8'h00);
        // bright frame shortens exposure, dim frame lengthens it
        for (f = 0; f < 2; f++) begin
            frame(f ? 8'h10 : 8'h20, f ? 8'h18 : 8'hFF);
            for (k = 0; k < 6; k++) rd(sa[k], se[f][k]);
        end
        wr(8'h0B);
        chk("valid", 8'h00, {7'h00, dumpWordValid});
        // nine read pairs cross the frame boundary and wrap to pixel zero
        for (k = 0; k < 9; k++) begin
            frame(8'h30 + 8'(k), 8'h90);
            chk("valid", 8'h01, {7'h00, dumpWordValid});
            chk("first", {7'h00, k % FRAME == 0}, {7'h00, dumpFrameStart});
            e = (k % 2) ? 8'h90 : 8'h30 + 8'(k);
            rd(8'h0B, e);
            chk("valid", 8'h00, {7'h00, dumpWordValid});
            rd(8'h0B, e);
        end
        conclude();
    end
endmodule
